// *** rtl/isr_pkg.sv ***
// Package for the I2C slave register control block: offsets, fields, types
package isr_pkg;
    // ************************************************************
    // Register offsets (16-bit special function addresses)
    // ************************************************************
    localparam logic [15:0] ADDR_RX_BYTE = 16'hf2a8;
    localparam logic [15:0] ADDR_OWN_ADDRESS = 16'hf2a9;
    localparam logic [15:0] ADDR_TX_BYTE = 16'hf2aa;
    localparam logic [15:0] ADDR_SLAVE_CONTROL = 16'hf2ab;
    localparam logic [15:0] ADDR_SLAVE_MODE = 16'hf2ac;
    localparam logic [15:0] ADDR_SLAVE_STATUS = 16'hf2ad;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTL_WAIT_RELEASE_BIT = 5;
    localparam int CTL_ACK_OUT_BIT = 7;
    localparam int MODE_ENABLE_BIT = 0;
    localparam int MODE_STOP_IE_BIT = 5;
    localparam int MODE_START_IE_BIT = 6;

    // ************************************************************
    // Reset values and bit-count slots
    // ************************************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] RESET_BITCNT = 4'h0;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_DATA_SLOT = 4'h7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_TX,
        ST_RX,
        ST_WAIT,
        ST_IGNORE
    } isr_state_t;

    typedef struct packed {
        logic direction;
        logic address_match;
        logic tx_error;
        logic ack_received;
        logic bus_busy;
    } isr_status_t;

    typedef struct packed {
        logic ack_out_value;
        logic start_irq_enable;
        logic stop_irq_enable;
        logic interface_enable;
    } isr_ctrl_t;
endpackage : isr_pkg

// *** rtl/isr_slave.sv ***
// I2C slave with register control, status flags and clock stretching
//
// Function
// - Eight-bit read/write transmit byte register shifted out on SDA when transmitting.
// - Writing one to wait release lets SCL go while the slave holds it low.
// - Wait release is write-only; zero does nothing, reads always return zero.
// - Acknowledge after each received data byte is the acknowledge value bit.
// - Enable bit one runs the slave; zero stops all bus activity; resets zero.
// - Enable zero holds every register but the mode interrupt enables, and every status flag, at its initial value.
// - Stop interrupt enable lets a detected stop raise the bus interrupt.
// - Start interrupt enable lets a detected start raise the bus interrupt.
// - Bus busy sets on start, clears on stop.
// - Acknowledge received flag captures SDA at every acknowledge slot, except in a transfer to a foreign address.
// - Transmit error sets when a sent bit differs from sampled SDA.
// - After a transmit error SDA is not driven for the rest of that byte, up to its acknowledge slot.
// - A write to the control register clears the transmit error flag; a new error detected in that cycle wins.
// - Address match sets when received address equals own address.
// - Direction sets on direction bit one; clears on start, stop or zero.
// - Status is read-only, bits 7 to 5 read zero, resets to zero.
// - Own address register holds the seven-bit address in bits 7 to 1.
// - Receive byte captures SDA on SCL rise in both directions, per byte.
// - After an acknowledge, SCL fall enters wait holding SCL low, interrupt raised.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module isr_slave (
    input wire logic ref_clk, // 250 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [15:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic scl_i, // SCL pin level
    output logic scl_o, // SCL drive value (always low)
    output logic scl_oe, // SCL pull-low enable
    input wire logic sda_i, // SDA pin level
    output logic sda_o, // SDA drive value (always low)
    output logic sda_oe, // SDA pull-low enable
    output logic bus_irq // Bus interrupt, one-cycle pulse
);
    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    wire scl_s = scl_sync_r[1];
    wire sda_s = sda_sync_r[1];
    wire scl_rise = scl_s && !scl_d_r;
    wire scl_fall = !scl_s && scl_d_r;
    wire start_det = scl_s && scl_d_r && !sda_s && sda_d_r;
    wire stop_det = scl_s && scl_d_r && sda_s && !sda_d_r;

    // ************************************************************
    // Registers
    // ************************************************************
    isr_pkg::isr_ctrl_t ctrl_r;
    isr_pkg::isr_status_t stat_r;
    isr_pkg::isr_status_t stat_nxt;
    isr_pkg::isr_state_t state_r;
    isr_pkg::isr_state_t state_nxt;
    isr_pkg::isr_state_t resume_r;
    isr_pkg::isr_state_t resume_nxt;
    logic [7:0] tx_byte_r;
    logic [7:1] own_addr_r;
    logic [7:0] rx_byte_r;
    logic [7:0] rx_byte_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] txsh_r;
    logic [7:0] txsh_nxt;
    logic [3:0] bitcnt_r;
    logic [3:0] bitcnt_nxt;
    logic mute_r;
    logic mute_nxt;
    logic sda_oe_nxt;
    logic scl_oe_nxt;
    logic irq_nxt;

    wire en = ctrl_r.interface_enable;
    wire wr_tx = reg_wr && (reg_addr == isr_pkg::ADDR_TX_BYTE);
    wire wr_ctl = reg_wr && (reg_addr == isr_pkg::ADDR_SLAVE_CONTROL);
    wire wr_mode = reg_wr && (reg_addr == isr_pkg::ADDR_SLAVE_MODE);
    wire wr_own = reg_wr && (reg_addr == isr_pkg::ADDR_OWN_ADDRESS);
    wire release_req = wr_ctl && reg_wdata[isr_pkg::CTL_WAIT_RELEASE_BIT];

    // Enable bit lives in mode; clearing it resets everything else but the interrupt enables
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= '0;
        end else if (wr_mode) begin
            ctrl_r.interface_enable <= reg_wdata[isr_pkg::MODE_ENABLE_BIT];
            ctrl_r.stop_irq_enable <= reg_wdata[isr_pkg::MODE_STOP_IE_BIT];
            ctrl_r.start_irq_enable <= reg_wdata[isr_pkg::MODE_START_IE_BIT];
            if (!reg_wdata[isr_pkg::MODE_ENABLE_BIT]) begin
                ctrl_r.ack_out_value <= 1'b0;
            end
        end else if (wr_ctl && en) begin
            ctrl_r.ack_out_value <= reg_wdata[isr_pkg::CTL_ACK_OUT_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_r <= isr_pkg::RESET_BYTE;
            own_addr_r <= 7'h00;
        end else if (!en) begin
            tx_byte_r <= isr_pkg::RESET_BYTE;
            own_addr_r <= 7'h00;
        end else begin
            if (wr_tx) begin
                tx_byte_r <= reg_wdata;
            end
            if (wr_own) begin
                own_addr_r <= reg_wdata[7:1];
            end
        end
    end

    // ************************************************************
    // Bus engine
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        resume_nxt = resume_r;
        stat_nxt = stat_r;
        rx_byte_nxt = rx_byte_r;
        shift_nxt = shift_r;
        txsh_nxt = txsh_r;
        bitcnt_nxt = bitcnt_r;
        mute_nxt = mute_r;
        sda_oe_nxt = sda_oe;
        scl_oe_nxt = scl_oe;
        irq_nxt = 1'b0;
        if (wr_ctl) begin
            stat_nxt.tx_error = 1'b0;
        end
        if (start_det) begin
            stat_nxt.bus_busy = 1'b1;
            stat_nxt.direction = 1'b0;
            stat_nxt.address_match = 1'b0;
            irq_nxt = ctrl_r.start_irq_enable;
            state_nxt = isr_pkg::ST_ADDR;
            // The SCL fall that closes the start wraps the count to zero
            bitcnt_nxt = isr_pkg::RESET_BITCNT - 4'h1;
            sda_oe_nxt = 1'b0;
            scl_oe_nxt = 1'b0;
            mute_nxt = 1'b0;
        end else if (stop_det) begin
            stat_nxt.bus_busy = 1'b0;
            stat_nxt.direction = 1'b0;
            irq_nxt = ctrl_r.stop_irq_enable;
            state_nxt = isr_pkg::ST_IDLE;
            sda_oe_nxt = 1'b0;
            scl_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                isr_pkg::ST_ADDR, isr_pkg::ST_TX, isr_pkg::ST_RX: begin
                    if (scl_rise) begin
                        if (bitcnt_r == isr_pkg::ACK_SLOT) begin
                            stat_nxt.ack_received = sda_s;
                        end else begin
                            shift_nxt = {shift_r[6:0], sda_s};
                            // Compare own drive against the wire
                            if (state_r == isr_pkg::ST_TX && !mute_r && txsh_r[7] != sda_s) begin
                                stat_nxt.tx_error = 1'b1;
                                mute_nxt = 1'b1;
                            end
                        end
                    end
                    if (scl_fall) begin
                        bitcnt_nxt = bitcnt_r + 4'h1;
                        sda_oe_nxt = 1'b0;
                        if (bitcnt_r == isr_pkg::LAST_DATA_SLOT) begin
                            if (state_r == isr_pkg::ST_ADDR) begin
                                if (shift_r[7:1] == own_addr_r) begin
                                    stat_nxt.address_match = 1'b1;
                                    stat_nxt.direction = shift_r[0];
                                    sda_oe_nxt = 1'b1;
                                end else begin
                                    state_nxt = isr_pkg::ST_IGNORE;
                                end
                            end else begin
                                rx_byte_nxt = shift_r;
                                if (state_r == isr_pkg::ST_RX) begin
                                    sda_oe_nxt = !ctrl_r.ack_out_value;
                                end
                            end
                        end else if (bitcnt_r == isr_pkg::ACK_SLOT) begin
                            // Wait state: hold SCL low
                            scl_oe_nxt = 1'b1;
                            irq_nxt = 1'b1;
                            mute_nxt = 1'b0;
                            resume_nxt = (state_r == isr_pkg::ST_ADDR) ?
                                (stat_r.direction ? isr_pkg::ST_TX : isr_pkg::ST_RX) : state_r;
                            state_nxt = isr_pkg::ST_WAIT;
                        end else if (state_r == isr_pkg::ST_TX) begin
                            txsh_nxt = {txsh_r[6:0], 1'b0};
                            sda_oe_nxt = !mute_nxt && !txsh_nxt[7];
                        end
                    end
                end
                isr_pkg::ST_WAIT: begin
                    if (release_req) begin
                        scl_oe_nxt = 1'b0;
                        state_nxt = resume_r;
                        bitcnt_nxt = isr_pkg::RESET_BITCNT;
                        txsh_nxt = tx_byte_r;
                        // SCL is still low here, so SDA may change
                        sda_oe_nxt = (resume_r == isr_pkg::ST_TX) && !tx_byte_r[7];
                    end
                end
                isr_pkg::ST_IDLE, isr_pkg::ST_IGNORE: begin
                end
                default: begin
                    state_nxt = isr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= isr_pkg::ST_IDLE;
            resume_r <= isr_pkg::ST_IDLE;
            stat_r <= '0;
            rx_byte_r <= isr_pkg::RESET_BYTE;
            shift_r <= isr_pkg::RESET_BYTE;
            txsh_r <= isr_pkg::RESET_BYTE;
            bitcnt_r <= isr_pkg::RESET_BITCNT;
            mute_r <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            bus_irq <= 1'b0;
        end else if (!en) begin
            // Soft reset while disabled
            state_r <= isr_pkg::ST_IDLE;
            resume_r <= isr_pkg::ST_IDLE;
            stat_r <= '0;
            rx_byte_r <= isr_pkg::RESET_BYTE;
            shift_r <= isr_pkg::RESET_BYTE;
            txsh_r <= isr_pkg::RESET_BYTE;
            bitcnt_r <= isr_pkg::RESET_BITCNT;
            mute_r <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            bus_irq <= 1'b0;
        end else begin
            state_r <= state_nxt;
            resume_r <= resume_nxt;
            stat_r <= stat_nxt;
            rx_byte_r <= rx_byte_nxt;
            shift_r <= shift_nxt;
            txsh_r <= txsh_nxt;
            bitcnt_r <= bitcnt_nxt;
            mute_r <= mute_nxt;
            sda_oe <= sda_oe_nxt;
            scl_oe <= scl_oe_nxt;
            bus_irq <= irq_nxt;
        end
    end

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;

    // ************************************************************
    // Read path
    // ************************************************************
    wire [7:0] status_view = {3'h0, stat_r};
    wire [7:0] ctl_view = {ctrl_r.ack_out_value, 7'h00};
    wire [7:0] mode_view = {1'b0, ctrl_r.start_irq_enable, ctrl_r.stop_irq_enable,
                            4'h0, ctrl_r.interface_enable};
    wire [7:0] rd_mux = (reg_addr == isr_pkg::ADDR_RX_BYTE) ? rx_byte_r :
                        (reg_addr == isr_pkg::ADDR_OWN_ADDRESS) ? {own_addr_r, 1'b0} :
                        (reg_addr == isr_pkg::ADDR_TX_BYTE) ? tx_byte_r :
                        (reg_addr == isr_pkg::ADDR_SLAVE_CONTROL) ? ctl_view :
                        (reg_addr == isr_pkg::ADDR_SLAVE_MODE) ? mode_view :
                        (reg_addr == isr_pkg::ADDR_SLAVE_STATUS) ? status_view : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_status_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == isr_pkg::ADDR_SLAVE_STATUS |=> reg_rdata[7:5] == 3'h0)
        else $error("status upper bits not zero");
    chk_wait_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == isr_pkg::ADDR_SLAVE_CONTROL |=> !reg_rdata[5])
        else $error("wait release read nonzero");
    chk_disable_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !en |=> stat_r == '0 && !scl_oe && !sda_oe)
        else $error("state not cleared while disabled");
    chk_ctl_clears_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && wr_ctl && !(state_r == isr_pkg::ST_TX && scl_rise) |=> !stat_r.tx_error)
        else $error("control write left error set");
    chk_start_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && start_det |=> stat_r.bus_busy && !stat_r.direction)
        else $error("start did not set busy");
    chk_stop_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && stop_det |=> !stat_r.bus_busy)
        else $error("stop did not clear busy");
    chk_start_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && start_det |=> bus_irq == $past(ctrl_r.start_irq_enable))
        else $error("start irq gating wrong");
    chk_stop_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && stop_det |=> bus_irq == $past(ctrl_r.stop_irq_enable))
        else $error("stop irq gating wrong");
    chk_release_scl: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && state_r == isr_pkg::ST_WAIT && release_req && !start_det && !stop_det
        |=> !scl_oe)
        else $error("release did not free SCL");
    chk_err_mutes: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && mute_r && state_r == isr_pkg::ST_TX |-> !sda_oe)
        else $error("SDA driven after error");
    chk_sda_scl_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        en && $rose(sda_oe) |-> !scl_d_r || scl_oe)
        else $error("SDA changed while SCL high");
endmodule : isr_slave

// *** testbench/isr_i2c_master.sv ***
// Behavioural I2C bus master that works the far side of the slave
`timescale 1ns/1ps
module isr_i2c_master (
    input wire logic scl_line, // Resolved SCL level
    input wire logic sda_line, // Resolved SDA level
    output logic scl_low, // High pulls SCL low
    output logic sda_low // High pulls SDA low
);
    // ************************************************************
    // Bit and frame tasks, 125 ns per bit
    // ************************************************************
    int stalls = 0;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // A released SCL may be held low by the slave, so wait on the line itself
    task automatic rise_scl();
        int n;
        scl_low = 1'b0;
        n = 0;
        while (scl_line !== 1'b1 && n < 2000) begin
            #1;
            n++;
        end
        if (n >= 2000) stalls++;
    endtask : rise_scl

    task automatic clk_bit(input logic b, output logic r);
        sda_low = ~b;
        #31;
        rise_scl();
        #31;
        r = sda_line;
        #31;
        scl_low = 1'b1;
        #32;
    endtask : clk_bit

    // Eight bits MSB first then the ninth slot; SCL is left low afterwards
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], q[i]);
        end
        clk_bit(ack_in, ack);
    endtask : xfer

    task automatic start_cond();
        sda_low = 1'b0;
        scl_low = 1'b0;
        #62;
        sda_low = 1'b1;
        #62;
        scl_low = 1'b1;
        #31;
    endtask : start_cond

    task automatic stop_cond();
        sda_low = 1'b1;
        #31;
        rise_scl();
        #62;
        sda_low = 1'b0;
        #62;
    endtask : stop_cond
endmodule : isr_i2c_master

// *** testbench/tb_isr_slave.sv ***
// Self-checking bench for the I2C slave register control block
`timescale 1ns/1ps
module tb_isr_slave;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic scl_o, scl_oe, sda_o, sda_oe, bus_irq;
    logic scl_low, sda_low, scl_line, sda_line;
    logic [7:0] irq_cnt = 8'h00;
    logic [7:0] base, q;
    logic ack;
    int fails = 0;
    int samples_checked = 0;

    // Open-drain lines with pull-ups
    assign scl_line = (scl_oe ? scl_o : 1'b1) & ~scl_low;
    assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_low;

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    isr_slave dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .bus_irq(bus_irq));

    isr_i2c_master m (.scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low),
        .sda_low(sda_low));

    always @(posedge ref_clk) begin
        if (bus_irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
    end

    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task automatic conclude();
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input string name, input logic [15:0] a, input logic [7:0] msk,
                       input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(name, reg_rdata & msk, exp);
    endtask : rdc

    task automatic all_zero(input string name);
        for (int a = 0; a < 7; a++) begin
            rdc(name, isr_pkg::ADDR_RX_BYTE + 16'(a), 8'hff, 8'h00);
        end
    endtask : all_zero

    task automatic wait_hold(input logic exp);
        for (int n = 0; n < 40 && scl_oe !== exp; n++) @(negedge ref_clk);
        chk("scl hold", {7'h00, scl_oe}, {7'h00, exp});
    endtask : wait_hold

    initial begin
        #300000;
        fails++;
        conclude();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        all_zero("reset value");
        wr(isr_pkg::ADDR_SLAVE_MODE, 8'h61);
        wr(isr_pkg::ADDR_OWN_ADDRESS, 8'ha4);
        wr(isr_pkg::ADDR_TX_BYTE, 8'h5a);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'ha0);
        rdc("mode", isr_pkg::ADDR_SLAVE_MODE, 8'hff, 8'h61);
        rdc("own address", isr_pkg::ADDR_OWN_ADDRESS, 8'hfe, 8'ha4);
        rdc("tx byte", isr_pkg::ADDR_TX_BYTE, 8'hff, 8'h5a);
        rdc("control", isr_pkg::ADDR_SLAVE_CONTROL, 8'hff, 8'h80);
        // Master writes one byte, slave answers with ack value one
        base = irq_cnt;
        m.start_cond();
        rdc("busy", isr_pkg::ADDR_SLAVE_STATUS, 8'hff, 8'h01);
        m.xfer(8'ha4, 1'b1, q, ack);
        chk("address ack", {7'h00, ack}, 8'h00);
        wait_hold(1'b1);
        rdc("status write", isr_pkg::ADDR_SLAVE_STATUS, 8'hff, 8'h09);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'ha0);
        wait_hold(1'b0);
        m.xfer(8'h3c, 1'b1, q, ack);
        chk("data ack", {7'h00, ack}, 8'h01);
        wait_hold(1'b1);
        rdc("rx byte", isr_pkg::ADDR_RX_BYTE, 8'hff, 8'h3c);
        rdc("ack flag", isr_pkg::ADDR_SLAVE_STATUS, 8'h02, 8'h02);
        // Second byte with ack value zero: slave must pull the ack slot low
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'h20);
        m.xfer(8'hc3, 1'b1, q, ack);
        chk("data ack low", {7'h00, ack}, 8'h00);
        wait_hold(1'b1);
        rdc("rx byte 2", isr_pkg::ADDR_RX_BYTE, 8'hff, 8'hc3);
        rdc("ack flag low", isr_pkg::ADDR_SLAVE_STATUS, 8'h02, 8'h00);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'h20);
        m.stop_cond();
        rdc("busy clear", isr_pkg::ADDR_SLAVE_STATUS, 8'h11, 8'h00);
        chk("irq write", irq_cnt - base, 8'h05);
        // Master reads one byte and refuses it; start interrupt masked
        wr(isr_pkg::ADDR_SLAVE_MODE, 8'h21);
        wr(isr_pkg::ADDR_TX_BYTE, 8'ha5);
        base = irq_cnt;
        m.start_cond();
        m.xfer(8'ha5, 1'b1, q, ack);
        wait_hold(1'b1);
        rdc("status read", isr_pkg::ADDR_SLAVE_STATUS, 8'hff, 8'h19);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'h20);
        m.xfer(8'hff, 1'b1, q, ack);
        chk("read data", q, 8'ha5);
        wait_hold(1'b1);
        rdc("rx echo", isr_pkg::ADDR_RX_BYTE, 8'hff, 8'ha5);
        rdc("nack flag", isr_pkg::ADDR_SLAVE_STATUS, 8'h02, 8'h02);
        // Released SDA for the next byte so that the stop can be made
        wr(isr_pkg::ADDR_TX_BYTE, 8'hff);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'h20);
        m.stop_cond();
        rdc("dir clear", isr_pkg::ADDR_SLAVE_STATUS, 8'h11, 8'h00);
        chk("irq read", irq_cnt - base, 8'h03);
        // Master clashes on the first data bit; stop interrupt masked
        wr(isr_pkg::ADDR_SLAVE_MODE, 8'h41);
        wr(isr_pkg::ADDR_TX_BYTE, 8'hf0);
        base = irq_cnt;
        m.start_cond();
        m.xfer(8'ha5, 1'b1, q, ack);
        wait_hold(1'b1);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'h20);
        m.xfer(8'h7f, 1'b0, q, ack);
        chk("muted data", q, 8'h7f);
        wait_hold(1'b1);
        rdc("tx error", isr_pkg::ADDR_SLAVE_STATUS, 8'h04, 8'h04);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'h00);
        rdc("error clear", isr_pkg::ADDR_SLAVE_STATUS, 8'h04, 8'h00);
        wait_hold(1'b1);
        wr(isr_pkg::ADDR_TX_BYTE, 8'hff);
        wr(isr_pkg::ADDR_SLAVE_CONTROL, 8'h20);
        m.stop_cond();
        chk("irq error", irq_cnt - base, 8'h03);
        // Foreign address is ignored, then the enable bit clears everything
        wr(isr_pkg::ADDR_SLAVE_MODE, 8'h01);
        m.start_cond();
        m.xfer(8'h20, 1'b1, q, ack);
        chk("foreign ack", {7'h00, ack}, 8'h01);
        wait_hold(1'b0);
        m.stop_cond();
        wr(isr_pkg::ADDR_SLAVE_MODE, 8'h00);
        wr(isr_pkg::ADDR_OWN_ADDRESS, 8'h42);
        all_zero("disabled value");
        m.start_cond();
        m.xfer(8'h00, 1'b1, q, ack);
        chk("disabled ack", {7'h00, ack}, 8'h01);
        rdc("disabled busy", isr_pkg::ADDR_SLAVE_STATUS, 8'hff, 8'h00);
        m.stop_cond();
        chk("stretch timeout", 8'(m.stalls), 8'h00);
        conclude();
    end
endmodule : tb_isr_slave
